// ---- core/timer_params.svh ----
// Constants for the capture/compare timer: register offsets, field positions and reset values.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define ADDR_COUNTER 4'h0
`define ADDR_MATCH_A 4'h1
`define ADDR_MATCH_B 4'h2
`define ADDR_MODE 4'h3
`define ADDR_CAPCMP 4'h4
`define ADDR_OUTCTL 4'h5
`define ADDR_PRESCALE 4'h6
`define MODE_OPHI 3
`define MODE_OPLO 2
`define MODE_FLIP 1
`define MODE_WRAP 0
`define CC_B_CAPTURE 2
`define CC_A_REVERSE 1
`define CC_A_CAPTURE 0
`define OUT_LEVEL 1
`define OUT_ENABLE 0
`define PS_ESB_HI 6
`define PS_ESB_LO 5
`define PS_ESA_HI 4
`define PS_ESA_LO 3
`define PS_DIV_HI 1
`define PS_DIV_LO 0
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define REG_ZERO 8'h00
`define EDGE_BOTH 2'h2
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h0
`define EDGE_NONE 2'h3
`endif

// ---- core/timer_pkg.sv ----
// Types shared by the capture/compare timer.
package timer_pkg;
    typedef enum logic [1:0] {MODE_STOP, MODE_FREE, MODE_EDGE_CLEAR, MODE_PULSE} op_mode_e;
    typedef struct packed {
        logic [3:0] adr;
        logic we;
        logic [31:0] dat;
    } bus_req_s;
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_s;
endpackage

// ---- core/capture_compare_timer.sv ----
// Free-running capture/compare timer with pulse output mode and a Wishbone register slave.
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "timer_params.svh"
module capture_compare_timer
    import timer_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DIV_W = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic trigger_in_a_i,
    input wire logic trigger_in_b_i,
    output logic timer_out_o,
    output logic match_a_irq_o,
    output logic match_b_irq_o
);
    logic [WIDTH-1:0] up_counter_reg;
    logic [WIDTH-1:0] match_capture_a_reg;
    logic [WIDTH-1:0] match_capture_b_reg;
    logic [7:0] mode_reg;
    logic [7:0] capcmp_reg;
    logic [7:0] outctl_reg;
    logic [7:0] prescale_reg;
    logic wrap_flag_reg;
    logic timer_out_reg;
    logic match_a_irq_reg;
    logic match_b_irq_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [DIV_W-1:0] div_reg;
    logic [1:0] sync_a_reg;
    logic [1:0] sync_b_reg;
    logic prev_a_reg;
    logic prev_b_reg;
    bus_req_s req;
    edge_s edge_a;
    edge_s edge_b;
    op_mode_e op_mode;
    logic tick;
    logic bus_wr;
    logic valid_a;
    logic reverse_a;
    logic valid_b;
    logic b_detect;
    logic match_a;
    logic match_b;
    logic a_is_capture;
    logic b_is_capture;
    logic counting;
    logic toggle;
    logic [DIV_W-1:0] div_limit;

    assign req = '{adr: adr_i[5:2], we: we_i, dat: dat_i};
    assign bus_wr = cyc_i && stb_i && req.we && !ack_reg && sel_i[0];
    assign op_mode = op_mode_e'({mode_reg[`MODE_OPHI], mode_reg[`MODE_OPLO]});
    assign counting = (op_mode == MODE_FREE) || (op_mode == MODE_PULSE) || (op_mode == MODE_EDGE_CLEAR);
    assign a_is_capture = capcmp_reg[`CC_A_CAPTURE];
    assign b_is_capture = capcmp_reg[`CC_B_CAPTURE];

    // Count clock prescaler: the count advances on a tick every (2^sel) system clocks.
    assign div_limit = DIV_W'((1 << prescale_reg[`PS_DIV_HI:`PS_DIV_LO]) - 1);
    assign tick = (div_reg == div_limit);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !counting || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + DIV_W'(1);
    end

    // Two-stage synchronisers; only the second stage feeds edge detection.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_a_reg <= 2'h0;
            sync_b_reg <= 2'h0;
            prev_a_reg <= 1'b0;
            prev_b_reg <= 1'b0;
        end
        else
        begin
            sync_a_reg <= {sync_a_reg[0], trigger_in_a_i};
            sync_b_reg <= {sync_b_reg[0], trigger_in_b_i};
            prev_a_reg <= sync_a_reg[1];
            prev_b_reg <= sync_b_reg[1];
        end
    end

    assign edge_a = '{rise: sync_a_reg[1] && !prev_a_reg, fall: !sync_a_reg[1] && prev_a_reg};
    assign edge_b = '{rise: sync_b_reg[1] && !prev_b_reg, fall: !sync_b_reg[1] && prev_b_reg};

    function automatic logic edge_hit(input edge_s e, input logic [1:0] es);
        case (es)
            `EDGE_FALL: edge_hit = e.fall;
            `EDGE_RISE: edge_hit = e.rise;
            `EDGE_BOTH: edge_hit = e.rise || e.fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    assign valid_a = edge_hit(edge_a, prescale_reg[`PS_ESA_HI:`PS_ESA_LO]);
    // The opposite edge of trigger A feeds reverse-phase capture into register A.
    // Both-edge or disabled selections have no opposite edge, so they never capture this way.
    always_comb
    begin
        case (prescale_reg[`PS_ESA_HI:`PS_ESA_LO])
            `EDGE_RISE: reverse_a = edge_a.fall;
            `EDGE_FALL: reverse_a = edge_a.rise;
            default: reverse_a = 1'b0;
        endcase
    end
    assign valid_b = edge_hit(edge_b, prescale_reg[`PS_ESB_HI:`PS_ESB_LO]);
    assign b_detect = prescale_reg[`PS_ESB_HI:`PS_ESB_LO] != `EDGE_NONE;

    assign match_a = counting && !a_is_capture && (up_counter_reg == match_capture_a_reg);
    assign match_b = counting && !b_is_capture && (up_counter_reg == match_capture_b_reg);

    // Counter: free mode never clears on compare; pulse mode restarts after A match.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !counting)
            up_counter_reg <= '0;
        else if (tick)
        begin
            if (op_mode == MODE_PULSE && match_a)
                up_counter_reg <= '0;
            else
                up_counter_reg <= up_counter_reg + WIDTH'(1);
        end
    end

    // A compare-equal state lasts one tick, so events fire on the tick that leaves it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_a_irq_reg <= 1'b0;
        else
            match_a_irq_reg <= (tick && match_a) ||
                               (counting && a_is_capture && valid_b);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_b_irq_reg <= 1'b0;
        else
            match_b_irq_reg <= (tick && match_b) ||
                               (counting && b_is_capture && valid_a);
    end

    // Register A capture: trigger B edge, or trigger A reverse phase with no interrupt.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_capture_a_reg <= '0;
        else if (counting && a_is_capture && capcmp_reg[`CC_A_REVERSE] && reverse_a)
            match_capture_a_reg <= up_counter_reg;
        else if (counting && a_is_capture && !capcmp_reg[`CC_A_REVERSE] && valid_b)
            match_capture_a_reg <= up_counter_reg;
        else if (bus_wr && req.adr == `ADDR_MATCH_A && !a_is_capture)
            match_capture_a_reg <= WIDTH'(req.dat);
    end

    // Register B capture uses only trigger A; trigger B edges never reach it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_capture_b_reg <= '0;
        else if (counting && b_is_capture && valid_a)
            match_capture_b_reg <= up_counter_reg;
        else if (bus_wr && req.adr == `ADDR_MATCH_B && !b_is_capture)
            match_capture_b_reg <= WIDTH'(req.dat);
    end

    // Wrap flag: set by hardware wins over a software clear in the same cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wrap_flag_reg <= 1'b0;
        else if (tick && op_mode == MODE_FREE && up_counter_reg == `COUNT_MAX)
            wrap_flag_reg <= 1'b1;
        else if (bus_wr && req.adr == `ADDR_MODE && !req.dat[`MODE_WRAP])
            wrap_flag_reg <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= `REG_ZERO;
            capcmp_reg <= `REG_ZERO;
            outctl_reg <= `REG_ZERO;
            prescale_reg <= `REG_ZERO;
        end
        else if (bus_wr)
        begin
            case (req.adr)
                `ADDR_MODE: mode_reg <= req.dat[7:0];
                `ADDR_CAPCMP: capcmp_reg <= req.dat[7:0];
                `ADDR_OUTCTL: outctl_reg <= req.dat[7:0];
                `ADDR_PRESCALE: prescale_reg <= req.dat[7:0];
                default: ;
            endcase
        end
    end

    // Output toggles; in pulse mode the level rises at restart and falls after B match.
    always_comb
    begin
        toggle = 1'b0;
        if (op_mode == MODE_PULSE)
            toggle = tick && (match_a || match_b);
        else if (a_is_capture && b_is_capture)
            toggle = mode_reg[`MODE_FLIP] && valid_a;
        else
            toggle = tick && (match_a || match_b);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            timer_out_reg <= 1'b0;
        else if (!outctl_reg[`OUT_ENABLE] || b_detect)
            timer_out_reg <= outctl_reg[`OUT_LEVEL];
        else if (op_mode == MODE_PULSE && tick && match_a)
            timer_out_reg <= 1'b1;
        else if (op_mode == MODE_PULSE && tick && match_b)
            timer_out_reg <= 1'b0;
        else if (toggle)
            timer_out_reg <= !timer_out_reg;
    end

    // Register read path; reading the counter has no side effect.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_reg <= '0;
        else
        begin
            case (req.adr)
                `ADDR_COUNTER: rdata_reg <= 32'(up_counter_reg);
                `ADDR_MATCH_A: rdata_reg <= 32'(match_capture_a_reg);
                `ADDR_MATCH_B: rdata_reg <= 32'(match_capture_b_reg);
                `ADDR_MODE: rdata_reg <= {24'h000000, mode_reg[7:1], wrap_flag_reg};
                `ADDR_CAPCMP: rdata_reg <= {24'h000000, capcmp_reg};
                `ADDR_OUTCTL: rdata_reg <= {24'h000000, outctl_reg};
                `ADDR_PRESCALE: rdata_reg <= {24'h000000, prescale_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= cyc_i && stb_i && !ack_reg;
    end

    assign ack_o = ack_reg;
    assign dat_o = rdata_reg;
    assign timer_out_o = timer_out_reg;
    assign match_a_irq_o = match_a_irq_reg;
    assign match_b_irq_o = match_b_irq_reg;

    // Counter, wrap flag and read path.
    a_counter_wraps: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && op_mode == MODE_FREE && up_counter_reg == `COUNT_MAX |=> up_counter_reg == `COUNT_ZERO)
        else $error("counter did not wrap");
    a_wrap_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && op_mode == MODE_FREE && up_counter_reg == `COUNT_MAX |=> wrap_flag_reg)
        else $error("wrap flag not set");
    a_wrap_only_free: assert property (@(posedge clk_i) disable iff (rst_i)
        op_mode != MODE_FREE && !wrap_flag_reg |=> !wrap_flag_reg)
        else $error("wrap flag set outside free mode");
    a_wrap_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap_flag_reg && !bus_wr |=> wrap_flag_reg)
        else $error("wrap flag cleared itself");
    a_free_no_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && op_mode == MODE_FREE && $stable(op_mode) && up_counter_reg != `COUNT_MAX
        |=> up_counter_reg == $past(up_counter_reg) + WIDTH'(1))
        else $error("free counter skipped");
    a_counter_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        !counting |=> up_counter_reg == `COUNT_ZERO)
        else $error("stopped counter not cleared");
    a_read_counter: assert property (@(posedge clk_i) disable iff (rst_i)
        req.adr == `ADDR_COUNTER |=> dat_o == 32'($past(up_counter_reg)))
        else $error("counter read returned a stale value");
    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");

    // Compare and capture events.
    a_irq_a_match: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && match_a |=> match_a_irq_o)
        else $error("missing A interrupt");
    a_irq_b_match: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && match_b |=> match_b_irq_o)
        else $error("missing B interrupt");
    a_irq_a_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !(tick && match_a) && !(counting && a_is_capture && valid_b) |=> !match_a_irq_o)
        else $error("spurious A interrupt");
    a_irq_b_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !(tick && match_b) && !(counting && b_is_capture && valid_a) |=> !match_b_irq_o)
        else $error("spurious B interrupt");
    a_capture_b_value: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && b_is_capture && valid_a |=> match_capture_b_reg == $past(up_counter_reg) && match_b_irq_o)
        else $error("B capture wrong");
    a_capture_a_value: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && a_is_capture && !capcmp_reg[`CC_A_REVERSE] && valid_b
        |=> match_capture_a_reg == $past(up_counter_reg) && match_a_irq_o)
        else $error("A capture wrong");
    a_b_ignores_trig_b: assert property (@(posedge clk_i) disable iff (rst_i)
        b_is_capture && !valid_a |=> $stable(match_capture_b_reg))
        else $error("B changed without a trigger A edge");
    a_a_role_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        a_is_capture && !valid_b && !reverse_a |=> $stable(match_capture_a_reg))
        else $error("capture register A overwritten");
    a_reverse_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && a_is_capture && capcmp_reg[`CC_A_REVERSE] && reverse_a && !valid_b
        |=> match_capture_a_reg == $past(up_counter_reg) && !match_a_irq_o)
        else $error("reverse capture wrong or raised interrupt");
    a_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_a.rise |-> $past(trigger_in_a_i, 2))
        else $error("trigger A edge not from the synchronised pin");
    a_sync_b: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_b.fall |-> !$past(trigger_in_b_i, 2))
        else $error("trigger B edge not from the synchronised pin");

    // Output pin; most checks only hold while the pin is enabled and trigger B detection is off.
    a_out_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
        b_detect ##1 b_detect && $stable(outctl_reg) |-> timer_out_o == outctl_reg[`OUT_LEVEL])
        else $error("output active with trigger B");
    a_out_match_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        op_mode == MODE_FREE && !(a_is_capture && b_is_capture) && tick && (match_a || match_b) &&
        outctl_reg[`OUT_ENABLE] && !b_detect |=> timer_out_o != $past(timer_out_o))
        else $error("output missed a compare toggle");
    a_flip_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        op_mode == MODE_FREE && a_is_capture && b_is_capture && mode_reg[`MODE_FLIP] && valid_a &&
        outctl_reg[`OUT_ENABLE] && !b_detect |=> timer_out_o != $past(timer_out_o))
        else $error("output missed a trigger A toggle");
    a_capture_quiet_out: assert property (@(posedge clk_i) disable iff (rst_i)
        op_mode == MODE_FREE && a_is_capture && b_is_capture && !mode_reg[`MODE_FLIP] &&
        outctl_reg[`OUT_ENABLE] && !b_detect |=> $stable(timer_out_o))
        else $error("output toggled with both registers capturing");
    a_pulse_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        op_mode == MODE_PULSE && tick && match_a && outctl_reg[`OUT_ENABLE] && !b_detect
        |=> up_counter_reg == `COUNT_ZERO && timer_out_o)
        else $error("pulse restart wrong");
    a_pulse_counts: assert property (@(posedge clk_i) disable iff (rst_i)
        op_mode == MODE_PULSE && $stable(op_mode) && tick && !match_a
        |=> up_counter_reg == $past(up_counter_reg) + WIDTH'(1))
        else $error("pulse period counter skipped");
    a_pulse_falls: assert property (@(posedge clk_i) disable iff (rst_i)
        op_mode == MODE_PULSE && tick && match_b && !match_a && outctl_reg[`OUT_ENABLE] && !b_detect
        |=> !timer_out_o)
        else $error("pulse did not end at B match");

    c_wrap: cover property (@(posedge clk_i) disable iff (rst_i) $rose(wrap_flag_reg));
    c_pulse: cover property (@(posedge clk_i) disable iff (rst_i) op_mode == MODE_PULSE && $fell(timer_out_o));
    c_capture_a: cover property (@(posedge clk_i) disable iff (rst_i) a_is_capture && valid_b);
    c_flip: cover property (@(posedge clk_i) disable iff (rst_i)
        a_is_capture && b_is_capture && mode_reg[`MODE_FLIP] && valid_a);
    c_reverse: cover property (@(posedge clk_i) disable iff (rst_i)
        capcmp_reg[`CC_A_REVERSE] && a_is_capture && reverse_a);
endmodule

// ---- tb/trigger_source.sv ----
// Model of the external trigger pins that feed the timer's capture inputs.
`timescale 1ns/1ps
module trigger_source (
    input wire logic clk_i,
    output logic trig_a_o,
    output logic trig_b_o
);
    initial
    begin
        trig_a_o = 1'b0;
        trig_b_o = 1'b0;
    end
    // Levels are held for whole cycles so the two-flop synchroniser never misses one.
    task automatic pulse(input bit sel, input int width);
        @(posedge clk_i);
        if (sel) trig_b_o <= 1'b1;
        else trig_a_o <= 1'b1;
        repeat (width) @(posedge clk_i);
        if (sel) trig_b_o <= 1'b0;
        else trig_a_o <= 1'b0;
        repeat (width) @(posedge clk_i);
    endtask
endmodule

// ---- tb/test_capture_compare_timer.sv ----
// Self-checking bench for the capture/compare timer.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_capture_compare_timer;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, trig_a, trig_b, tout, irq_a, irq_b;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] c0, c1, qa, qb;
    int num_errors = 0, samples_checked = 0, na = 0, nb = 0, nt = 0, a0, b0, t0, hi, lo, k;
    logic tout_prev = 1'b0;
    always #5 clk_i = ~clk_i;
    capture_compare_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .trigger_in_a_i(trig_a),
        .trigger_in_b_i(trig_b), .timer_out_o(tout), .match_a_irq_o(irq_a), .match_b_irq_o(irq_b));
    trigger_source p (.clk_i(clk_i), .trig_a_o(trig_a), .trig_b_o(trig_b));
    always @(posedge clk_i)
    begin
        na <= na + int'(irq_a === 1'b1);
        nb <= nb + int'(irq_b === 1'b1);
        nt <= nt + int'(tout !== tout_prev && !rst_i);
        tout_prev <= tout;
    end
    task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) num_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rd(input logic [3:0] i);
        bus(1'b0, i, 32'h0);
    endtask
    task automatic snap();
        a0 = na;
        b0 = nb;
        t0 = nt;
    endtask
    task automatic wait_level(input logic v, output int n);
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (tout !== v && n < 100);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
        begin
            rd(i[3:0]);
            `CHK(q, 32'h0)
        end
    endtask
    task automatic t_compare();
        wr(4'h1, 32'h100);
        wr(4'h2, 32'h200);
        wr(4'h5, 32'h1);
        wr(4'h6, 32'h60);
        wr(4'h3, 32'h4);
        rd(4'h0);
        c0 = q[15:0];
        rd(4'h0);
        `CHK(q[15:0] - c0, 16'h0003)
        k = 0;
        do
        begin
            rd(4'h0);
            k++;
        end while (q[15:0] < 16'h0210 && k < 1000);
        `CHK(q[15:0] > 16'h0200, 1'b1)
        `CHK(na, 1)
        `CHK(nb, 1)
        `CHK(nt, 2)
    endtask
    task automatic t_wrap();
        k = 0;
        do
        begin
            rd(4'h3);
            k++;
        end while (q[0] !== 1'b1 && k < 30000);
        rd(4'h0);
        `CHK(q[15:0] < 16'h0010, 1'b1)
        wr(4'h3, 32'h5);
        rd(4'h3);
        `CHK(q[3:0], 4'h5)
        wr(4'h3, 32'h4);
        rd(4'h3);
        `CHK(q[3:0], 4'h4)
    endtask
    task automatic t_capture();
        wr(4'h4, 32'h7);
        wr(4'h6, 32'h68);
        wr(4'h2, 32'h1234);
        snap();
        rd(4'h0);
        c0 = q[15:0];
        p.pulse(1'b0, 8);
        rd(4'h0);
        c1 = q[15:0];
        rd(4'h1);
        qa = q[15:0];
        rd(4'h2);
        qb = q[15:0];
        `CHK(nb - b0, 1)
        `CHK(na - a0, 0)
        `CHK(qb > c0 && qb < c1, 1'b1)
        `CHK(qa - qb, 16'h0008)
        `CHK(nt - t0, 0)
    endtask
    task automatic t_trig_b();
        wr(4'h4, 32'h5);
        wr(4'h6, 32'h58);
        wr(4'h5, 32'h3);
        rd(4'h2);
        qb = q[15:0];
        snap();
        rd(4'h0);
        c0 = q[15:0];
        p.pulse(1'b1, 6);
        rd(4'h0);
        c1 = q[15:0];
        rd(4'h1);
        `CHK(q[15:0] > c0 && q[15:0] < c1, 1'b1)
        `CHK(na - a0, 2)
        `CHK(nb - b0, 0)
        `CHK(nt - t0, 0)
        `CHK(tout, 1'b1)
        rd(4'h2);
        `CHK(q[15:0], qb)
    endtask
    task automatic t_flip();
        wr(4'h3, 32'h6);
        wr(4'h6, 32'h68);
        snap();
        p.pulse(1'b0, 4);
        repeat (8) @(posedge clk_i);
        `CHK(nt - t0, 1)
        `CHK(nb - b0, 1)
    endtask
    task automatic t_pulse();
        wr(4'h4, 32'h0);
        wr(4'h3, 32'h0);
        wr(4'h1, 32'h9);
        wr(4'h2, 32'h3);
        wr(4'h3, 32'hC);
        wait_level(1'b0, hi);
        wait_level(1'b1, hi);
        wait_level(1'b0, hi);
        wait_level(1'b1, lo);
        `CHK(hi, 4)
        `CHK(hi + lo, 10)
        rd(4'h0);
        `CHK(q[15:0] <= 16'h0009, 1'b1)
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_compare();
        t_wrap();
        t_capture();
        t_trig_b();
        t_flip();
        t_pulse();
        tally_and_finish();
    end
    // The full wrap alone costs about 65536 cycles, so the limit sits well above it.
    initial
    begin
        repeat (98000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
endmodule
